// File: design/mtmr_consts.svh
// Purpose: offsets, field positions, reset values and encodings for the modulo timer
// Assumes: included by the package and by the timer module
// Notes:   register offsets are byte offsets on the plain register port
`ifndef MTMR_CONSTS_SVH
`define MTMR_CONSTS_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define MTMR_OFF_SC      4'h0
`define MTMR_OFF_CLK     4'h1
`define MTMR_OFF_CNT     4'h2
`define MTMR_OFF_MOD     4'h3
`define MTMR_OFF_IRQST   4'h4
`define MTMR_OFF_IRQMSK  4'h5

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define MTMR_SC_OVF      7
`define MTMR_SC_OVIE     6
`define MTMR_SC_CLR      5
`define MTMR_SC_HALT     4
`define MTMR_CLK_SRC_HI  5
`define MTMR_CLK_SRC_LO  4
`define MTMR_CLK_PS_HI   3
`define MTMR_CLK_PS_LO   0

// ----------------------------------------------------------------------
// encodings and reset values
// ----------------------------------------------------------------------
`define MTMR_SRC_BUS     2'h0
`define MTMR_SRC_FIX     2'h1
`define MTMR_SRC_EXTF    2'h2
`define MTMR_SRC_EXTR    2'h3
`define MTMR_PS_MAX      4'h8
`define MTMR_RST_BYTE    8'h00
`define MTMR_RST_HALT    1'h1
`define MTMR_RST_PS      4'h0
`define MTMR_RST_SRC     2'h0
`define MTMR_PRE_ONE     9'h001
`define MTMR_RST_BIT     1'h0
`define MTMR_RST_PRE     9'h000
`define MTMR_RST_SYNC    3'h0

`endif

// File: design/mtmr_pkg.sv
// Purpose: types shared by the modulo timer
// Assumes: constants come from mtmr_consts.svh
// Notes:   the whole timer state is one packed struct
`include "mtmr_consts.svh"

package mtmr_pkg;

	typedef logic [7:0] mtmr_byte_t;
	typedef logic [3:0] mtmr_addr_t;

	typedef enum logic [1:0] {
		MTMR_RUN,
		MTMR_WAITM,
		MTMR_STOPM,
		MTMR_BDM
	} mtmr_mode_t;

	typedef struct packed {
		mtmr_byte_t  count;
		mtmr_byte_t  modVal;
		logic        ovfFlag;
		logic        ovfIrqEn;
		logic        haltBit;
		logic [1:0]  clkSrc;
		logic [3:0]  preSel;
		logic [8:0]  preCnt;
		logic [2:0]  extSync;
		logic        extLast;
		logic [2:0]  fixSync;
		logic        fixLast;
		logic        irqSt;
		logic        irqMsk;
		logic        irqOut;
		mtmr_byte_t  rdData;
		logic        wakeReq;
	} mtmr_state_t;

endpackage

// File: design/modulo_timer.sv
// Purpose: 8-bit modulo up-counter timer with clock select, prescaler, overflow interrupt
// Assumes: 20 MHz clk, registers on a plain strobe port, read data one cycle after the strobe
// Notes:   low-power and debug modes arrive as plain inputs from the system controller
//
// Contract
// - 8-bit up-counter, free running or wrapping at a programmable modulo limit
// - overflow interrupt request, enabled or disabled by a control bit
// - writing the counter-clear bit resets the counter
// - count-halt bit stops the counter while set
// - prescaler input: bus clock, fixed clock, external pin rising or falling edge
// - prescaler divides by 1, 2, 4, 8, 16, 32, 64, 128 or 256
// - a running timer keeps counting in wait mode
// - enabled overflow interrupt can wake the processor from wait
// - timer disabled in every stop mode, never a stop wake source
// - waking from the two deepest stop modes returns the timer to reset
// - shallow stop left through reset puts the timer in reset state
// - shallow stop left through interrupt keeps state, counting resumes from held value
// - debug background mode suspends all counting
// - after background, resume from held value unless cleared or modulo written
// - source code 00 bus, 01 fixed, 10 pin falling, 11 pin rising
// - prescale code n divides by two to the n, codes above 1000 divide by 256
// - changing source or prescale while counting does not clear the counter
//
// Chosen here: the address map and strobed register access.
`timescale 1ns/1ps
`include "mtmr_consts.svh"

module modulo_timer
(
	input  wire logic                clk,
	input  wire logic                rstn,
	input  wire mtmr_pkg::mtmr_addr_t regAddr,
	input  wire mtmr_pkg::mtmr_byte_t regWrData,
	input  wire logic                regWrStb,
	input  wire logic                regRdStb,
	output mtmr_pkg::mtmr_byte_t      regRdData,
	input  wire logic                fixedFreqClock,
	input  wire logic                externalTimerClockPin,
	input  wire logic                waitMode,
	input  wire logic                stopMode,
	input  wire logic                deepStopWake,
	input  wire logic                bgdMode,
	output logic                     timerIrq,
	output logic                     waitWakeReq
);
	import mtmr_pkg::*;

	mtmr_state_t st_ff;
	mtmr_state_t nxt_st;

	// ----------------------------------------------------------------------
	// combinational next state
	// ----------------------------------------------------------------------
	logic       wrSc;
	logic       wrClk;
	logic       wrMod;
	logic       srcEdge;
	logic       tick;
	logic       extRise;
	logic       extFall;
	logic       fixRise;
	logic       running;
	logic [8:0] preLimit;
	logic       ovfEvent;
	logic [3:0] psEff;

	always_comb
	begin
		nxt_st   = st_ff;
		wrSc     = regWrStb && (regAddr == `MTMR_OFF_SC);
		wrClk    = regWrStb && (regAddr == `MTMR_OFF_CLK);
		wrMod    = regWrStb && (regAddr == `MTMR_OFF_MOD);

		// ----------------------------------------------------------------------
		// pin synchronisers
		// ----------------------------------------------------------------------
		// pins pass three flops; an edge counts once stages two and three agree
		nxt_st.extSync = {st_ff.extSync[1:0], externalTimerClockPin};
		nxt_st.fixSync = {st_ff.fixSync[1:0], fixedFreqClock};
		if (st_ff.extSync[2] == st_ff.extSync[1])
		begin
			nxt_st.extLast = st_ff.extSync[2];
		end
		if (st_ff.fixSync[2] == st_ff.fixSync[1])
		begin
			nxt_st.fixLast = st_ff.fixSync[2];
		end
		extRise = (st_ff.extSync[2] == st_ff.extSync[1]) && st_ff.extSync[2] && !st_ff.extLast;
		extFall = (st_ff.extSync[2] == st_ff.extSync[1]) && !st_ff.extSync[2] && st_ff.extLast;
		fixRise = (st_ff.fixSync[2] == st_ff.fixSync[1]) && st_ff.fixSync[2] && !st_ff.fixLast;

		// ----------------------------------------------------------------------
		// clock source select
		// ----------------------------------------------------------------------
		case (st_ff.clkSrc)
			`MTMR_SRC_FIX:  srcEdge = fixRise;
			`MTMR_SRC_EXTF: srcEdge = extFall;
			`MTMR_SRC_EXTR: srcEdge = extRise;
			default:        srcEdge = 1'b1;
		endcase

		// ----------------------------------------------------------------------
		// prescaler
		// ----------------------------------------------------------------------
		// stop and background freeze counting; wait does not
		running = !st_ff.haltBit && !stopMode && !bgdMode;

		psEff    = (st_ff.preSel > `MTMR_PS_MAX) ? `MTMR_PS_MAX : st_ff.preSel;
		preLimit = 9'(`MTMR_PRE_ONE << psEff);
		tick     = 1'b0;
		ovfEvent = 1'b0;
		if (running && srcEdge)
		begin
			// a shrunk ratio lands the prescaler past its new limit: roll at once
			if (9'(st_ff.preCnt + 9'h001) >= preLimit)
			begin
				nxt_st.preCnt = 9'h000;
				tick          = 1'b1;
			end
			else
			begin
				nxt_st.preCnt = 9'(st_ff.preCnt + 9'h001);
			end
		end

		// ----------------------------------------------------------------------
		// counter
		// ----------------------------------------------------------------------
		// modulo zero means free running through 0xff
		if (tick)
		begin
			if (st_ff.count == st_ff.modVal && st_ff.modVal != `MTMR_RST_BYTE)
			begin
				nxt_st.count = `MTMR_RST_BYTE;
				ovfEvent     = 1'b1;
			end
			else if (st_ff.modVal == `MTMR_RST_BYTE && st_ff.count == 8'hff)
			begin
				nxt_st.count = `MTMR_RST_BYTE;
				ovfEvent     = 1'b1;
			end
			else
			begin
				nxt_st.count = 8'(st_ff.count + 8'h01);
			end
		end

		// ----------------------------------------------------------------------
		// register writes
		// ----------------------------------------------------------------------
		if (wrSc)
		begin
			nxt_st.ovfIrqEn = regWrData[`MTMR_SC_OVIE];
			nxt_st.haltBit  = regWrData[`MTMR_SC_HALT];
			if (regWrData[`MTMR_SC_CLR])
			begin
				nxt_st.count  = `MTMR_RST_BYTE;
				nxt_st.preCnt = 9'h000;
			end
			// flag clears by writing zero to it while it reads set
			if (!regWrData[`MTMR_SC_OVF])
			begin
				nxt_st.ovfFlag = 1'b0;
			end
		end
		if (wrClk)
		begin
			nxt_st.clkSrc = regWrData[`MTMR_CLK_SRC_HI:`MTMR_CLK_SRC_LO];
			nxt_st.preSel = regWrData[`MTMR_CLK_PS_HI:`MTMR_CLK_PS_LO];
		end
		if (wrMod)
		begin
			nxt_st.modVal = regWrData;
			nxt_st.count  = `MTMR_RST_BYTE;
			nxt_st.preCnt = 9'h000;
			nxt_st.ovfFlag = 1'b0;
		end
		if (regWrStb && regAddr == `MTMR_OFF_IRQST && regWrData[0])
		begin
			nxt_st.irqSt = 1'b0;
		end
		if (regWrStb && regAddr == `MTMR_OFF_IRQMSK)
		begin
			nxt_st.irqMsk = regWrData[0];
		end

		// ----------------------------------------------------------------------
		// interrupt flags and outputs
		// ----------------------------------------------------------------------
		// events win over a clear in the same cycle
		if (ovfEvent)
		begin
			nxt_st.ovfFlag = 1'b1;
			nxt_st.irqSt   = 1'b1;
		end

		nxt_st.irqOut  = nxt_st.irqSt && nxt_st.irqMsk && nxt_st.ovfIrqEn;
		nxt_st.wakeReq = waitMode && nxt_st.ovfFlag && nxt_st.ovfIrqEn;

		// ----------------------------------------------------------------------
		// register reads
		// ----------------------------------------------------------------------
		nxt_st.rdData = `MTMR_RST_BYTE;
		if (regRdStb)
		begin
			if (regAddr == `MTMR_OFF_SC)
			begin
				nxt_st.rdData[`MTMR_SC_OVF]  = st_ff.ovfFlag;
				nxt_st.rdData[`MTMR_SC_OVIE] = st_ff.ovfIrqEn;
				nxt_st.rdData[`MTMR_SC_HALT] = st_ff.haltBit;
			end
			else if (regAddr == `MTMR_OFF_CLK)
			begin
				nxt_st.rdData[`MTMR_CLK_SRC_HI:`MTMR_CLK_SRC_LO] = st_ff.clkSrc;
				nxt_st.rdData[`MTMR_CLK_PS_HI:`MTMR_CLK_PS_LO]   = st_ff.preSel;
			end
			else if (regAddr == `MTMR_OFF_CNT)
			begin
				nxt_st.rdData = st_ff.count;
			end
			else if (regAddr == `MTMR_OFF_MOD)
			begin
				nxt_st.rdData = st_ff.modVal;
			end
			else if (regAddr == `MTMR_OFF_IRQST)
			begin
				nxt_st.rdData = {7'h00, st_ff.irqSt};
			end
			else if (regAddr == `MTMR_OFF_IRQMSK)
			begin
				nxt_st.rdData = {7'h00, st_ff.irqMsk};
			end
		end

		// ----------------------------------------------------------------------
		// deep stop wake
		// ----------------------------------------------------------------------
		// deep stop wake resets every timer field except the pin synchronisers and the read data
		if (deepStopWake)
		begin
			nxt_st.count    = `MTMR_RST_BYTE;
			nxt_st.modVal   = `MTMR_RST_BYTE;
			nxt_st.ovfFlag  = 1'b0;
			nxt_st.ovfIrqEn = 1'b0;
			nxt_st.haltBit  = `MTMR_RST_HALT;
			nxt_st.clkSrc   = `MTMR_RST_SRC;
			nxt_st.preSel   = `MTMR_RST_PS;
			nxt_st.preCnt   = 9'h000;
			nxt_st.irqSt    = 1'b0;
			nxt_st.irqMsk   = 1'b0;
			nxt_st.irqOut   = 1'b0;
			nxt_st.wakeReq  = 1'b0;
		end
	end

	// ----------------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------------
	// shallow stop exit by reset arrives on rstn; exit by interrupt keeps state
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			st_ff.count    <= `MTMR_RST_BYTE;
			st_ff.modVal   <= `MTMR_RST_BYTE;
			st_ff.ovfFlag  <= `MTMR_RST_BIT;
			st_ff.ovfIrqEn <= `MTMR_RST_BIT;
			st_ff.haltBit  <= `MTMR_RST_HALT;
			st_ff.clkSrc   <= `MTMR_RST_SRC;
			st_ff.preSel   <= `MTMR_RST_PS;
			st_ff.preCnt   <= `MTMR_RST_PRE;
			st_ff.extSync  <= `MTMR_RST_SYNC;
			st_ff.extLast  <= `MTMR_RST_BIT;
			st_ff.fixSync  <= `MTMR_RST_SYNC;
			st_ff.fixLast  <= `MTMR_RST_BIT;
			st_ff.irqSt    <= `MTMR_RST_BIT;
			st_ff.irqMsk   <= `MTMR_RST_BIT;
			st_ff.irqOut   <= `MTMR_RST_BIT;
			st_ff.rdData   <= `MTMR_RST_BYTE;
			st_ff.wakeReq  <= `MTMR_RST_BIT;
		end
		else
		begin
			st_ff <= nxt_st;
		end
	end

	assign regRdData   = st_ff.rdData;
	assign timerIrq    = st_ff.irqOut;
	assign waitWakeReq = st_ff.wakeReq;

endmodule // modulo_timer

// File: dv/mtmr_asserts.sv
// Purpose: port checks for the modulo timer
// Assumes: register writes and the mode pins are the only causes of state change
// Notes:   shadow copies of written fields stand in for the hidden registers
`timescale 1ns/1ps
module mtmr_asserts
(
	input wire logic                 clk,
	input wire logic                 rstn,
	input wire mtmr_pkg::mtmr_addr_t regAddr,
	input wire mtmr_pkg::mtmr_byte_t regWrData,
	input wire logic                 regWrStb,
	input wire logic                 regRdStb,
	input wire mtmr_pkg::mtmr_byte_t regRdData,
	input wire logic                 fixedFreqClock,
	input wire logic                 externalTimerClockPin,
	input wire logic                 waitMode,
	input wire logic                 stopMode,
	input wire logic                 deepStopWake,
	input wire logic                 bgdMode,
	input wire logic                 timerIrq,
	input wire logic                 waitWakeReq
);
	import mtmr_pkg::*;
	// --------------------------------------------------------
	// shadow of written fields
	// --------------------------------------------------------
	mtmr_byte_t modTrk;
	logic       ieTrk;
	logic       mskTrk;
	logic       haltTrk;
	logic       frz;
	logic       cntRd;
	assign frz = haltTrk || stopMode || bgdMode;
	assign cntRd = regRdStb && regAddr == 4'h2;
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			{modTrk, ieTrk, mskTrk, haltTrk} <= {8'h00, 3'h1};
		else if (deepStopWake)
			{modTrk, ieTrk, mskTrk, haltTrk} <= {8'h00, 3'h1};
		else if (regWrStb && regAddr == 4'h0)
			{ieTrk, haltTrk} <= {regWrData[6], regWrData[4]};
		else if (regWrStb && regAddr == 4'h3)
			modTrk <= regWrData;
		else if (regWrStb && regAddr == 4'h5)
			mskTrk <= regWrData[0];
	end
	// --------------------------------------------------------
	// properties
	// --------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	property p_frz; cntRd && frz && !deepStopWake ##1 cntRd && frz |=> $stable(regRdData); endproperty
	property p_clr; regWrStb && regAddr == 4'h0 && regWrData[5] && regWrData[4] ##1 cntRd |=> regRdData == 8'h00; endproperty
	property p_modClr; regWrStb && regAddr == 4'h3 && haltTrk ##1 cntRd |=> regRdData == 8'h00; endproperty
	property p_cntMod; $past(cntRd) && $past(modTrk) != 8'h00 |-> regRdData <= $past(modTrk); endproperty
	// shadows already hold last cycle's writes, just as the registered outputs do
	property p_irq; timerIrq |-> ieTrk && mskTrk; endproperty
	property p_wake; waitWakeReq |-> $past(waitMode) && ieTrk; endproperty
	property p_deep; deepStopWake ##1 regRdStb && regAddr == 4'h0 |=> regRdData == 8'h10; endproperty
	property p_deepClk; deepStopWake ##2 regRdStb && regAddr == 4'h1 |=> regRdData == 8'h00; endproperty
	a_frz: assert property (p_frz) else $error("count moved while frozen");
	a_clr: assert property (p_clr) else $error("clear left count");
	a_modClr: assert property (p_modClr) else $error("modulo write left count");
	a_cntMod: assert property (p_cntMod) else $error("count above modulo");
	a_irq: assert property (p_irq) else $error("irq without enable");
	a_wake: assert property (p_wake) else $error("wake outside wait");
	a_deep: assert property (p_deep) else $error("control not reset");
	a_deepClk: assert property (p_deepClk) else $error("clock config not reset");
	c_irq: cover property (timerIrq);
	c_wake: cover property (waitWakeReq);
	c_deep: cover property (deepStopWake ##1 regRdStb);
endmodule // mtmr_asserts

bind modulo_timer mtmr_asserts mtmr_asserts_i (.clk, .rstn, .regAddr, .regWrData, .regWrStb, .regRdStb, .regRdData,
	.fixedFreqClock, .externalTimerClockPin, .waitMode, .stopMode, .deepStopWake, .bgdMode, .timerIrq, .waitWakeReq);

// File: dv/modulo_timer_test.sv
// Purpose: self-checking bench for the modulo timer
// Assumes: read data stand only in the cycle after the read strobe
// Notes:   steps are judged from two counter reads a known distance apart, so tick phase drops out
`timescale 1ns/1ps
module modulo_timer_test;
	import mtmr_pkg::*;
	logic       clk = 0, rstn = 0, regWrStb = 0, regRdStb = 0, fixedFreqClock = 0, externalTimerClockPin = 0;
	logic       waitMode = 0, stopMode = 0, deepStopWake = 0, bgdMode = 0, timerIrq, waitWakeReq;
	mtmr_addr_t regAddr = 4'h0;
	mtmr_byte_t regWrData = 8'h00, regRdData, a, b, m, rnd = 8'h17;
	int         err_count = 0, cmp_count = 0, cyc = 0, dv, n;
	always #25 clk = ~clk;
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		fixedFreqClock <= cyc[2];
		externalTimerClockPin <= cyc[1];
	end
	modulo_timer modulo_timer_i (.clk, .rstn, .regAddr, .regWrData, .regWrStb, .regRdStb, .regRdData,
		.fixedFreqClock, .externalTimerClockPin, .waitMode, .stopMode, .deepStopWake, .bgdMode, .timerIrq, .waitWakeReq);
	// --------------------------------------------------------
	// helpers
	// --------------------------------------------------------
	function automatic mtmr_byte_t lfsr(input mtmr_byte_t s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input mtmr_byte_t seen, input mtmr_byte_t exp);
		cmp_count++;
		if (seen !== exp)
		begin
			err_count++;
			$display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	// strobes stay up until the next task call, so accesses may run back to back
	task automatic acc(input logic w, input mtmr_addr_t ad, input mtmr_byte_t d);
		@(posedge clk);
		regWrStb <= w;
		regRdStb <= !w;
		regAddr <= ad;
		regWrData <= d;
	endtask
	task automatic idle;
		@(posedge clk);
		regWrStb <= 0;
		regRdStb <= 0;
	endtask
	task automatic rd(input mtmr_addr_t ad, input mtmr_byte_t exp);
		acc(0, ad, 8'h00);
		idle();
		@(negedge clk);
		chk(regRdData, exp);
	endtask
	task automatic pair(input int d);
		for (int i = 0; i <= d + 1; i++)
		begin
			if (i == 0 || i == d)
				acc(0, 4'h2, 8'h00);
			else
				idle();
			@(negedge clk);
			if (i == 1)
				a = regRdData;
			if (i == d + 1)
				b = regRdData;
		end
	endtask
	initial
	begin
		#2ms;
		err_count++;
		complete_run();
	end
	// --------------------------------------------------------
	// main sequence
	// --------------------------------------------------------
	initial
	begin
		repeat (5) @(posedge clk);
		rstn <= 1;
		rd(4'h0, 8'h10);
		rd(4'h1, 8'h00);
		rd(4'h7, 8'h00);
		for (int s = 0; s < 4; s++)
			for (int p = 0; p <= (s == 0 ? 9 : 1); p++)
			begin
				rnd = lfsr(rnd);
				m = (p == 2) ? 8'h00 : {6'h01, rnd[1:0]};
				dv = (s == 0 ? 1 : s == 1 ? 8 : 4) << (p > 8 ? 8 : p);
				acc(1, 4'h3, m);
				acc(1, 4'h1, {2'h0, s[1:0], p[3:0]});
				acc(1, 4'h0, 8'h00);
				idle();
				repeat (8 + rnd[7:4]) @(posedge clk);
				pair(3 * dv);
				chk(b, mtmr_byte_t'((a + 3) % (m == 8'h00 ? 256 : m + 1)));
			end
		acc(1, 4'h1, 8'h00);
		acc(1, 4'h3, 8'h04);
		acc(1, 4'h4, 8'h01);
		acc(1, 4'h5, 8'h01);
		acc(1, 4'h0, 8'h40);
		idle();
		waitMode <= 1;
		pair(3);
		chk(b, mtmr_byte_t'((a + 3) % 5));
		for (n = 0; n < 12 && waitWakeReq !== 1'b1; n++)
			@(negedge clk);
		chk({7'h0, waitWakeReq}, 8'h01);
		chk({7'h0, timerIrq}, 8'h01);
		rd(4'h4, 8'h01);
		for (int j = 0; j < 2; j++)
		begin
			@(posedge clk);
			waitMode <= 0;
			stopMode <= (j == 0);
			bgdMode <= (j == 1);
			pair(1);
			chk(b, a);
			@(posedge clk);
			stopMode <= 0;
			bgdMode <= 0;
			pair(3);
			chk(b, mtmr_byte_t'((a + 3) % 5));
		end
		acc(1, 4'h5, 8'h00);
		idle();
		@(posedge clk);
		@(negedge clk);
		chk({7'h0, timerIrq}, 8'h00);
		acc(1, 4'h0, 8'h50);
		acc(1, 4'h0, 8'h50);
		acc(1, 4'h4, 8'h01);
		acc(1, 4'h3, 8'h06);
		rd(4'h2, 8'h00);
		acc(1, 4'h0, 8'h40);
		idle();
		repeat (2) @(posedge clk);
		acc(1, 4'h1, 8'h01);
		rd(4'h2, 8'h04);
		acc(1, 4'h0, 8'h30);
		rd(4'h2, 8'h00);
		pair(1);
		chk(b, a);
		rd(4'h0, 8'h10);
		rd(4'h4, 8'h00);
		acc(1, 4'h0, 8'h40);
		acc(1, 4'h1, 8'h23);
		idle();
		deepStopWake <= 1;
		acc(0, 4'h0, 8'h00);
		deepStopWake <= 0;
		acc(0, 4'h1, 8'h00);
		@(negedge clk);
		chk(regRdData, 8'h10);
		idle();
		@(negedge clk);
		chk(regRdData, 8'h00);
		rd(4'h3, 8'h00);
		complete_run();
	end
endmodule // modulo_timer_test
